// ===== uef_pkg.sv
package uef_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int DATA_W = 8;
  localparam int FIFO_DEPTH = 32;

  // ----------------------------------------------------------------
  // register offsets, general bank (enh_bank_i = 0)
  // ----------------------------------------------------------------
  localparam logic [2:0] OFS_DATA = 3'h0;
  localparam logic [2:0] OFS_IER = 3'h1;
  localparam logic [2:0] OFS_ISR_FCR = 3'h2;
  localparam logic [2:0] OFS_MCR = 3'h4;
  localparam logic [2:0] OFS_SPR = 3'h7;

  // ----------------------------------------------------------------
  // register offsets, enhanced bank (enh_bank_i = 1)
  // ----------------------------------------------------------------
  localparam logic [2:0] OFS_FC_TRG = 3'h0;
  localparam logic [2:0] OFS_FEATURE_CONTROL = 3'h1;
  localparam logic [2:0] OFS_EFR = 3'h2;
  localparam logic [2:0] OFS_DLD = 3'h3;
  localparam logic [2:0] OFS_RES1 = 3'h4;
  localparam logic [2:0] OFS_RES2 = 3'h5;
  localparam logic [2:0] OFS_PAU1 = 3'h6;
  localparam logic [2:0] OFS_PAU2 = 3'h7;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int FEATURE_CONTROL_HYST_LO = 0;
  localparam int FEATURE_CONTROL_HYST_HI = 1;
  localparam int FEATURE_CONTROL_IRINV = 2;
  localparam int FEATURE_CONTROL_TBL_LO = 4;
  localparam int FEATURE_CONTROL_TBL_HI = 5;
  localparam int FEATURE_CONTROL_SWAP = 6;
  localparam int FEATURE_CONTROL_SEL = 7;
  localparam int EFR_RXF_LO = 0;
  localparam int EFR_RXF_HI = 1;
  localparam int EFR_TXF_LO = 2;
  localparam int EFR_TXF_HI = 3;
  localparam int EFR_ENH = 4;
  localparam int EFR_SPEC = 5;
  localparam int EFR_ARTS = 6;
  localparam int EFR_ACTS = 7;
  localparam int ENHANCED_MODE_SELECT_CNT_LO = 0;
  localparam int ENHANCED_MODE_SELECT_CNT_HI = 1;
  localparam int ENHANCED_MODE_SELECT_HYST_LO = 4;
  localparam int ENHANCED_MODE_SELECT_HYST_HI = 5;
  localparam int IER_LOCK_LO = 4;
  localparam int IER_SPEC = 5;
  localparam int FCR_LOCK_LO = 4;
  localparam int FCR_LOCK_HI = 5;
  localparam int MCR_LOCK_LO = 5;
  localparam int MCR_RTS = 1;

  // ----------------------------------------------------------------
  // reset and read values
  // ----------------------------------------------------------------
  localparam logic [7:0] SPR_RST = 8'hFF;
  localparam logic [7:0] ENHANCED_MODE_SELECT_RST = 8'h80;
  localparam logic [7:0] ISR_IDLE = 8'h01;
  localparam logic [7:0] ISR_FLOW = 8'h10;

  // ----------------------------------------------------------------
  // modes and states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    FLOW_NONE = 2'b00,
    FLOW_SECOND = 2'b01,
    FLOW_FIRST = 2'b10,
    FLOW_BOTH = 2'b11
  } uef_flow_t;

  typedef enum logic [1:0] {
    TXS_IDLE = 2'b00,
    TXS_FIRST = 2'b01,
    TXS_SECOND = 2'b10
  } uef_txs_t;

  typedef enum logic [1:0] {
    RXS_IDLE = 2'b00,
    RXS_ON1 = 2'b01,
    RXS_OFF1 = 2'b10
  } uef_rxs_t;

  // rts hysteresis in characters, index {enhanced_mode_select[5:4], feature_control[1:0]}
  function automatic logic [8:0] uef_hyst(input logic [3:0] sel);
    logic [8:0] h;
    h = 9'h000;
    case (sel)
      4'h1: h = 9'h004;
      4'h2: h = 9'h006;
      4'h3: h = 9'h008;
      4'h4: h = 9'h008;
      4'h5: h = 9'h010;
      4'h6: h = 9'h018;
      4'h7: h = 9'h020;
      4'h8: h = 9'h028;
      4'h9: h = 9'h02C;
      4'hA: h = 9'h030;
      4'hB: h = 9'h034;
      4'hC: h = 9'h00C;
      4'hD: h = 9'h014;
      4'hE: h = 9'h01C;
      4'hF: h = 9'h024;
      default: h = 9'h000;
    endcase
    return h;
  endfunction

endpackage

// ===== uef_fifo_if.sv
`timescale 1ns/1ps
interface uef_fifo_if #(parameter int W = 8, parameter int CW = 6);
  logic wvalid;
  logic wready;
  logic [W-1:0] wdata;
  logic rvalid;
  logic rready;
  logic [W-1:0] rdata;
  logic [CW-1:0] count;
  modport fifo (input wvalid, input wdata, input rready,
                output wready, output rvalid, output rdata, output count);
  modport user (output wvalid, output wdata, output rready,
                input wready, input rvalid, input rdata, input count);
endinterface

// ===== uef_fifo.sv
`timescale 1ns/1ps
module uef_fifo
  import uef_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH,
  parameter int W = DATA_W
) (
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  uef_fifo_if.fifo port
);
  // depth must be a power of two so the pointers wrap by themselves
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH) + 1;

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [CW-1:0] cnt;
  } uef_fifo_st_t;

  uef_fifo_st_t r;
  uef_fifo_st_t n;
  logic push;
  logic pop;

  assign port.wready = (r.cnt != CW'(DEPTH));
  assign port.rvalid = (r.cnt != '0);
  assign port.rdata = r.mem[r.rp];
  assign port.count = r.cnt;
  assign push = port.wvalid && port.wready;
  assign pop = port.rready && port.rvalid;

  always_comb begin
    n = r;
    if (push) begin
      n.mem[r.wp] = port.wdata;
      n.wp = r.wp + AW'(1);
    end
    if (pop) begin
      n.rp = r.rp + AW'(1);
    end
    if (push && !pop) begin
      n.cnt = r.cnt + CW'(1);
    end else if (pop && !push) begin
      n.cnt = r.cnt - CW'(1);
    end
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  a_fifo_bound: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    r.cnt <= CW'(DEPTH))
    else $error("fifo count above depth");
  a_fifo_full_hold: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    (!port.wready && !pop) |=> (r.cnt == $past(r.cnt)))
    else $error("full fifo took a word");
endmodule

// ===== uef_feature_ctrl.sv
`timescale 1ns/1ps
// Contract
// - count register reads receive count when select bit 0, transmit when 1
// - hysteresis field picks rts hysteresis, reset clears it
// - receive inversion bit chooses idle-low or inverted idle-high infrared input
// - trigger table field picks table a, b, c or d
// - swap off: scratchpad is plain read/write storage
// - swap on: reads give fifo counts, writes go to mode select
// - select bit steers trigger and count registers to receive or transmit
// - bits 3:2 choose transmit flow characters, single or paired sequence
// - bits 1:0 choose receive comparison, either pair or sequence
// - paired transmit sends two characters in order; paired receive matches in order only if transmit mode is paired or off
// - enhanced bits change only while enable bit set, else latched
// - reset clears locked enhanced bits and fractional divisor
// - special detect compares with second pause character, stores it, flags
// - second-pair compare withholds matching char, raises pause and special flags
// - first-pair compare keeps flow control and special detect independent
// - auto rts flags trigger, rises at upper level, falls below lower
// - auto cts stops transmit on high, resumes on low
// - cts stop waits for the current character to finish
// - alternating count mode returns receive count first, then transmit
module uef_feature_ctrl
  import uef_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  input wire logic cs_n_i,
  input wire logic rd_i,
  input wire logic wr_i,
  input wire logic enh_bank_i,
  input wire logic [2:0] addr_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o,
  input wire logic rx_pin_i,
  output logic rx_line_o,
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_data_i,
  output logic rx_ready_o,
  output logic tx_valid_o,
  output logic [7:0] tx_data_o,
  input wire logic tx_ready_i,
  input wire logic cts_n_i,
  output logic rts_n_o,
  output logic rx_trig_irq_o,
  output logic flow_irq_o,
  output logic [7:0] ier_o,
  output logic [1:0] fcr_ext_o,
  output logic [7:0] mcr_o,
  output logic [7:0] frac_div_o,
  output logic [1:0] trig_table_o,
  output logic [7:0] trg_tx_o
);
  localparam int CW = $clog2(DEPTH) + 1;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] rdata;
    logic [7:0] interrupt_enable;
    logic [1:0] fcr_ext;
    logic [7:0] modem_control;
    logic [7:0] fractional_divisor;
    logic [7:0] spr;
    logic [7:0] enhanced_mode_select;
    logic [7:0] feature_control;
    logic [7:0] enhanced_feature;
    logic [7:0] res1;
    logic [7:0] res2;
    logic [7:0] pau1;
    logic [7:0] pau2;
    logic [7:0] trg_rx;
    logic [7:0] trg_tx;
    logic alt_tx;
    logic flag_spec;
    logic flag_pause;
    logic tx_halt;
    uef_txs_t txs;
    logic tx_kind;
    logic paused_sent;
    uef_rxs_t rxs;
    logic tx_valid;
    logic [7:0] tx_data;
    logic rx_rdy;
    logic rts_n;
    logic rx_line;
    logic trig_irq;
    logic flow_irq;
  } uef_st_t;

  uef_st_t r;
  uef_st_t n;
  logic [7:0] rx_cnt8;
  logic [7:0] tx_cnt8;
  logic [8:0] upper;
  logic [8:0] lower;

  uef_fifo_if #(.W(DATA_W), .CW(CW)) rxf ();
  uef_fifo_if #(.W(DATA_W), .CW(CW)) txf ();

  uef_fifo #(.DEPTH(DEPTH), .W(DATA_W)) u_rx_fifo (
    .sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .port(rxf)
  );

  uef_fifo #(.DEPTH(DEPTH), .W(DATA_W)) u_tx_fifo (
    .sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .port(txf)
  );

  assign rx_cnt8 = 8'(rxf.count);
  assign tx_cnt8 = 8'(txf.count);

  // ----------------------------------------------------------------
  // thresholds
  // ----------------------------------------------------------------
  // hysteresis around trigger
  always_comb begin
    logic [8:0] h;
    h = uef_hyst({r.enhanced_mode_select[ENHANCED_MODE_SELECT_HYST_HI:ENHANCED_MODE_SELECT_HYST_LO], r.feature_control[FEATURE_CONTROL_HYST_HI:FEATURE_CONTROL_HYST_LO]});
    upper = {1'b0, r.trg_rx} + h;
    lower = ({1'b0, r.trg_rx} > h) ? ({1'b0, r.trg_rx} - h) : 9'h000;
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic rd_hit;
    logic wr_hit;
    logic lock_open;
    logic above;
    logic below;
    logic p1, p2, r1, r2;
    logic seq;
    logic is_pause;
    logic is_res;
    logic take;
    logic cts_ok;
    logic second;
    uef_flow_t rxm;
    uef_flow_t txm;
    rd_hit = !cs_n_i && rd_i;
    wr_hit = !cs_n_i && wr_i;
    lock_open = r.enhanced_feature[EFR_ENH];
    above = ({1'b0, rx_cnt8} >= upper) && (rx_cnt8 != 8'h00);
    below = ({1'b0, rx_cnt8} < lower);
    rxm = uef_flow_t'(r.enhanced_feature[EFR_RXF_HI:EFR_RXF_LO]);
    txm = uef_flow_t'(r.enhanced_feature[EFR_TXF_HI:EFR_TXF_LO]);
    p1 = (rx_data_i == r.pau1);
    p2 = (rx_data_i == r.pau2);
    r1 = (rx_data_i == r.res1);
    r2 = (rx_data_i == r.res2);
    seq = (rxm == FLOW_BOTH) && (txm == FLOW_BOTH || txm == FLOW_NONE);
    take = rx_valid_i && r.rx_rdy;
    cts_ok = !(r.enhanced_feature[EFR_ACTS] && cts_n_i);
    second = 1'b0;
    is_pause = 1'b0;
    is_res = 1'b0;
    n = r;
    txf.wvalid = 1'b0;
    txf.wdata = wdata_i;
    txf.rready = 1'b0;
    rxf.wvalid = 1'b0;
    rxf.wdata = rx_data_i;
    rxf.rready = 1'b0;

    // ---------------------------------------------------------------
    // register writes
    // ---------------------------------------------------------------
    if (wr_hit && !enh_bank_i) begin
      case (addr_i)
        OFS_DATA: txf.wvalid = 1'b1;
        OFS_IER: n.interrupt_enable = lock_open ? wdata_i :
                         {r.interrupt_enable[7:IER_LOCK_LO], wdata_i[IER_LOCK_LO-1:0]};
        OFS_ISR_FCR: if (lock_open) n.fcr_ext = wdata_i[FCR_LOCK_HI:FCR_LOCK_LO];
        OFS_MCR: n.modem_control = lock_open ? wdata_i :
                         {r.modem_control[7:MCR_LOCK_LO], wdata_i[MCR_LOCK_LO-1:0]};
        OFS_SPR: begin
          // swapped writes land in mode select
          if (r.feature_control[FEATURE_CONTROL_SWAP]) begin
            n.enhanced_mode_select = wdata_i;
            n.alt_tx = 1'b0;
          end else begin
            n.spr = wdata_i;
          end
        end
        default: n.rdata = r.rdata;
      endcase
    end else if (wr_hit) begin
      case (addr_i)
        // trigger register steered by select bit
        OFS_FC_TRG: begin
          if (r.feature_control[FEATURE_CONTROL_SEL]) n.trg_tx = wdata_i;
          else n.trg_rx = wdata_i;
        end
        OFS_FEATURE_CONTROL: n.feature_control = wdata_i;
        OFS_EFR: n.enhanced_feature = wdata_i;
        OFS_DLD: if (lock_open) n.fractional_divisor = wdata_i;
        OFS_RES1: n.res1 = wdata_i;
        OFS_RES2: n.res2 = wdata_i;
        OFS_PAU1: n.pau1 = wdata_i;
        OFS_PAU2: n.pau2 = wdata_i;
        default: n.rdata = r.rdata;
      endcase
    end

    // ---------------------------------------------------------------
    // register reads, registered one cycle later
    // ---------------------------------------------------------------
    if (rd_hit && !enh_bank_i) begin
      case (addr_i)
        OFS_DATA: begin
          n.rdata = rxf.rdata;
          rxf.rready = 1'b1;
        end
        OFS_IER: n.rdata = r.interrupt_enable;
        OFS_ISR_FCR: begin
          n.rdata = (r.flag_pause || r.flag_spec) ? ISR_FLOW : ISR_IDLE;
          n.flag_pause = 1'b0;
          n.flag_spec = 1'b0;
        end
        OFS_MCR: n.rdata = r.modem_control;
        OFS_SPR: begin
          if (!r.feature_control[FEATURE_CONTROL_SWAP]) begin
            n.rdata = r.spr;
          end else if (!r.enhanced_mode_select[ENHANCED_MODE_SELECT_CNT_LO]) begin
            n.rdata = rx_cnt8;
          end else if (!r.enhanced_mode_select[ENHANCED_MODE_SELECT_CNT_HI]) begin
            n.rdata = tx_cnt8;
          end else begin
            n.rdata = r.alt_tx ? tx_cnt8 : rx_cnt8;
            n.alt_tx = !r.alt_tx;
          end
        end
        default: n.rdata = 8'h00;
      endcase
    end else if (rd_hit) begin
      case (addr_i)
        OFS_FC_TRG: n.rdata = r.feature_control[FEATURE_CONTROL_SEL] ? tx_cnt8 : rx_cnt8;
        OFS_FEATURE_CONTROL: n.rdata = r.feature_control;
        OFS_EFR: n.rdata = r.enhanced_feature;
        OFS_DLD: n.rdata = r.fractional_divisor;
        OFS_RES1: n.rdata = r.res1;
        OFS_RES2: n.rdata = r.res2;
        OFS_PAU1: n.rdata = r.pau1;
        OFS_PAU2: n.rdata = r.pau2;
        default: n.rdata = 8'h00;
      endcase
    end

    // ---------------------------------------------------------------
    // receive compare; events set after the read clear so a set wins
    // ---------------------------------------------------------------
    // receive comparison modes
    case (rxm)
      FLOW_FIRST: begin
        is_pause = p1;
        is_res = r1;
      end
      FLOW_SECOND: begin
        is_pause = p2;
        is_res = r2;
      end
      FLOW_BOTH: begin
        is_pause = seq ? (r.rxs == RXS_OFF1 && p2) : (p1 || p2);
        is_res = seq ? (r.rxs == RXS_ON1 && r2) : (r1 || r2);
      end
      default: begin
        is_pause = 1'b0;
        is_res = 1'b0;
      end
    endcase
    if (take) begin
      if (seq) n.rxs = p1 ? RXS_OFF1 : (r1 ? RXS_ON1 : RXS_IDLE);
      if (is_pause) begin
        n.tx_halt = 1'b1;
        n.flag_pause = 1'b1;
      end
      if (is_res) n.tx_halt = 1'b0;
      // special detect against second pause character
      if (r.enhanced_feature[EFR_SPEC] && p2) n.flag_spec = 1'b1;
      // flow characters stay out of the fifo, except the first of a sequenced pair
      rxf.wvalid = !(is_pause || is_res);
    end
    // one slot of margin covers the registered ready
    n.rx_rdy = (rxf.count <= CW'(DEPTH - 2));

    // ---------------------------------------------------------------
    // transmit: flow characters take priority over fifo data
    // ---------------------------------------------------------------
    // start pause or resume sequence on fill level
    if (txm != FLOW_NONE && r.txs == TXS_IDLE) begin
      if (!r.paused_sent && above) begin
        n.txs = TXS_FIRST;
        n.tx_kind = 1'b1;
        n.paused_sent = 1'b1;
      end else if (r.paused_sent && below) begin
        n.txs = TXS_FIRST;
        n.tx_kind = 1'b0;
        n.paused_sent = 1'b0;
      end
    end
    if (r.tx_valid && tx_ready_i) n.tx_valid = 1'b0;
    // cts gates only the next hand-off, never the running one
    if ((!r.tx_valid || tx_ready_i) && cts_ok) begin
      if (r.txs != TXS_IDLE) begin
        // paired mode sends first then second character
        second = (r.txs == TXS_SECOND) || (txm == FLOW_SECOND);
        n.tx_data = r.tx_kind ? (second ? r.pau2 : r.pau1) : (second ? r.res2 : r.res1);
        n.tx_valid = 1'b1;
        n.txs = (r.txs == TXS_FIRST && txm == FLOW_BOTH) ? TXS_SECOND : TXS_IDLE;
      end else if (txf.rvalid && !(r.tx_halt && rxm != FLOW_NONE)) begin
        n.tx_data = txf.rdata;
        n.tx_valid = 1'b1;
        txf.rready = 1'b1;
      end
    end

    // ---------------------------------------------------------------
    // rts, interrupts, infrared input
    // ---------------------------------------------------------------
    // auto rts needs rts asserted by software first
    if (r.enhanced_feature[EFR_ARTS] && r.modem_control[MCR_RTS]) begin
      if (above) n.rts_n = 1'b1;
      else if (below) n.rts_n = 1'b0;
    end else begin
      n.rts_n = !r.modem_control[MCR_RTS];
    end
    n.trig_irq = r.enhanced_feature[EFR_ARTS] && (rx_cnt8 >= r.trg_rx) && (rx_cnt8 != 8'h00);
    n.flow_irq = r.interrupt_enable[IER_SPEC] && (r.flag_pause || r.flag_spec);
    n.rx_line = rx_pin_i ^ r.feature_control[FEATURE_CONTROL_IRINV];
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      r <= '0;
      r.spr <= SPR_RST;
      r.enhanced_mode_select <= ENHANCED_MODE_SELECT_RST;
      r.rts_n <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign rdata_o = r.rdata;
  assign rx_line_o = r.rx_line;
  assign rx_ready_o = r.rx_rdy;
  assign tx_valid_o = r.tx_valid;
  assign tx_data_o = r.tx_data;
  assign rts_n_o = r.rts_n;
  assign rx_trig_irq_o = r.trig_irq;
  assign flow_irq_o = r.flow_irq;
  assign ier_o = r.interrupt_enable;
  assign fcr_ext_o = r.fcr_ext;
  assign mcr_o = r.modem_control;
  assign frac_div_o = r.fractional_divisor;
  // table select straight from the register
  assign trig_table_o = r.feature_control[FEATURE_CONTROL_TBL_HI:FEATURE_CONTROL_TBL_LO];
  assign trg_tx_o = r.trg_tx;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_fc_rx_count: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    (!cs_n_i && rd_i && enh_bank_i && addr_i == OFS_FC_TRG && !r.feature_control[FEATURE_CONTROL_SEL])
    |=> (rdata_o == $past(rx_cnt8)))
    else $error("count read did not return receive count");
  a_dld_locked: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    (!cs_n_i && wr_i && enh_bank_i && addr_i == OFS_DLD && !r.enhanced_feature[EFR_ENH])
    |=> $stable(frac_div_o))
    else $error("locked divisor fraction changed");
  a_dld_open: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    (!cs_n_i && wr_i && enh_bank_i && addr_i == OFS_DLD && r.enhanced_feature[EFR_ENH])
    |=> (frac_div_o == $past(wdata_i)))
    else $error("open divisor fraction write lost");
  a_spr_plain: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    (!cs_n_i && rd_i && !wr_i && !enh_bank_i && addr_i == OFS_SPR && !r.feature_control[FEATURE_CONTROL_SWAP])
    |=> (rdata_o == $past(r.spr)))
    else $error("scratch read mismatch");
  a_swap_write: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    (!cs_n_i && wr_i && !enh_bank_i && addr_i == OFS_SPR && r.feature_control[FEATURE_CONTROL_SWAP])
    |=> ($stable(r.spr) && r.enhanced_mode_select == $past(wdata_i)))
    else $error("swapped write reached scratch");
  a_alt_order: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    (!cs_n_i && rd_i && !enh_bank_i && addr_i == OFS_SPR && r.feature_control[FEATURE_CONTROL_SWAP]
     && r.enhanced_mode_select[ENHANCED_MODE_SELECT_CNT_HI:ENHANCED_MODE_SELECT_CNT_LO] == 2'b11 && !r.alt_tx)
    |=> (rdata_o == $past(rx_cnt8) && r.alt_tx))
    else $error("alternate mode did not give receive count first");
  a_cts_hold: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    (r.enhanced_feature[EFR_ACTS] && cts_n_i && !tx_valid_o) |=> !tx_valid_o)
    else $error("transmit started while cts high");
  a_cts_finish: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    (tx_valid_o && !tx_ready_i) |=> (tx_valid_o && $stable(tx_data_o)))
    else $error("character in flight dropped");
  a_spec_withhold: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    (rx_valid_i && rx_ready_o && r.enhanced_feature[EFR_SPEC] && r.enhanced_feature[EFR_RXF_HI:EFR_RXF_LO] == 2'b01
     && rx_data_i == r.pau2)
    |=> (r.flag_pause && r.flag_spec && rxf.count <= $past(rxf.count)))
    else $error("second pause character not withheld");
  a_rts_upper: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    (r.enhanced_feature[EFR_ARTS] && r.modem_control[MCR_RTS] && rx_cnt8 != 8'h00 && {1'b0, rx_cnt8} >= upper)
    |=> rts_n_o)
    else $error("rts not raised at upper level");
  a_ir_invert: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    1'b1 |=> (rx_line_o == ($past(rx_pin_i) ^ $past(r.feature_control[FEATURE_CONTROL_IRINV]))))
    else $error("receive inversion wrong");
endmodule

// ===== uef_remote.sv
`timescale 1ns/1ps
module uef_remote (
  input wire logic sys_clk_i,
  input wire logic rx_ready_i,
  input wire logic slow_i,
  output logic rx_valid_o,
  output logic [7:0] rx_data_o,
  output logic tx_ready_o,
  input wire logic tx_valid_i,
  input wire logic [7:0] tx_data_i,
  output logic [7:0] got_o,
  output logic [7:0] got_cnt_o
);
  initial begin
    rx_valid_o = 1'b0;
    rx_data_o = 8'h00;
    tx_ready_o = 1'b0;
    got_o = 8'h00;
    got_cnt_o = 8'h00;
  end
  // keeps the last character taken and how many, so order and pairs can be checked
  always @(posedge sys_clk_i) begin
    if (tx_valid_i === 1'b1 && tx_ready_o === 1'b1) begin
      got_o <= tx_data_i;
      got_cnt_o <= got_cnt_o + 8'h01;
    end
  end
  // a slow station only takes every other cycle
  always @(negedge sys_clk_i) begin
    tx_ready_o <= slow_i ? !tx_ready_o : 1'b1;
  end
  task automatic send(input logic [7:0] c);
    @(negedge sys_clk_i);
    rx_valid_o = 1'b1;
    rx_data_o = c;
    do @(posedge sys_clk_i); while (rx_ready_i !== 1'b1);
    @(negedge sys_clk_i);
    rx_valid_o = 1'b0;
    // released line shows garbage, not the last character
    rx_data_o = ~c;
  endtask
endmodule

// ===== tb_uart_enhanced_feature_control.sv
`timescale 1ns/1ps
module tb_uart_enhanced_feature_control import uef_pkg::*; ;
  logic clk = 0, rstn = 0, cs_n = 1, rd = 0, wr = 0, bank = 0, pin = 0, slow = 0, cts = 0;
  logic [2:0] addr = 0;
  logic [7:0] wd = 0, rdat, rxd, txd, fractional_divisor, got, gcnt, modem_control, interrupt_enable, trgtx;
  logic [1:0] tbl, fcx;
  logic rxl, rxv, rxr, txr, txv, rts, trig, flow;
  int errors = 0, cmp_count = 0;
  always #2 clk = ~clk;
  uef_remote rem_u (.sys_clk_i(clk), .rx_ready_i(rxr), .slow_i(slow), .rx_valid_o(rxv),
    .rx_data_o(rxd), .tx_ready_o(txr), .tx_valid_i(txv), .tx_data_i(txd), .got_o(got),
    .got_cnt_o(gcnt));
  uef_feature_ctrl dut_u (.sys_clk_i(clk), .rstn_i(rstn), .cs_n_i(cs_n), .rd_i(rd),
    .wr_i(wr), .enh_bank_i(bank), .addr_i(addr), .wdata_i(wd), .rdata_o(rdat),
    .rx_pin_i(pin), .rx_line_o(rxl), .rx_valid_i(rxv), .rx_data_i(rxd), .rx_ready_o(rxr),
    .tx_valid_o(txv), .tx_data_o(txd), .tx_ready_i(txr), .cts_n_i(cts), .rts_n_o(rts),
    .rx_trig_irq_o(trig), .flow_irq_o(flow), .ier_o(interrupt_enable), .fcr_ext_o(fcx), .mcr_o(modem_control),
    .frac_div_o(fractional_divisor), .trig_table_o(tbl), .trg_tx_o(trgtx));
  // ----------------------------------------
  // bus tasks
  // ----------------------------------------
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("wrong value at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  task automatic acc(input logic b, input logic [2:0] a, input logic w, input logic [7:0] d);
    @(negedge clk);
    cs_n = 1'b0;
    bank = b;
    addr = a;
    wr = w;
    rd = !w;
    wd = d;
    @(negedge clk);
    cs_n = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
  endtask
  task automatic wrr(input logic b, input logic [2:0] a, input logic [7:0] d);
    acc(b, a, 1'b1, d);
  endtask
  task automatic rdc(input logic b, input logic [2:0] a, input logic [7:0] e);
    acc(b, a, 1'b0, 8'h00);
    chk(rdat, e);
  endtask
  task automatic end_sim;
    $display("compares %0d, mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    #40000;
    errors++;
    end_sim;
  end
  initial begin
    repeat (20) @(negedge clk);
    rstn = 1'b1;
    repeat (2) @(negedge clk);
    rdc(1'b1, OFS_FEATURE_CONTROL, 8'h00);
    rdc(1'b1, OFS_EFR, 8'h00);
    rdc(1'b1, OFS_DLD, 8'h00);
    rdc(1'b0, OFS_SPR, SPR_RST);
    wrr(1'b0, OFS_SPR, 8'h5A);
    rdc(1'b0, OFS_SPR, 8'h5A);
    $display("reset and scratch test done");
    for (int i = 0; i < 4; i++) begin
      wrr(1'b1, OFS_FEATURE_CONTROL, {2'b00, i[1:0], 4'h0});
      chk({6'h00, tbl}, i[7:0]);
    end
    pin = 1'b1;
    wrr(1'b1, OFS_FEATURE_CONTROL, 8'h04);
    @(negedge clk);
    chk({7'h00, rxl}, 8'h00);
    wrr(1'b1, OFS_FEATURE_CONTROL, 8'h00);
    @(negedge clk);
    chk({7'h00, rxl}, 8'h01);
    $display("feature control test done");
    wrr(1'b1, OFS_DLD, 8'h55);
    rdc(1'b1, OFS_DLD, 8'h00);
    wrr(1'b1, OFS_EFR, 8'h10);
    wrr(1'b1, OFS_DLD, 8'h55);
    wrr(1'b1, OFS_EFR, 8'h00);
    wrr(1'b1, OFS_DLD, 8'hAA);
    rdc(1'b1, OFS_DLD, 8'h55);
    chk(fractional_divisor, 8'h55);
    $display("lock test done");
    for (int i = 0; i < 3; i++) rem_u.send(8'h41 + i[7:0]);
    repeat (2) @(negedge clk);
    rdc(1'b1, OFS_FC_TRG, 8'h03);
    wrr(1'b1, OFS_FEATURE_CONTROL, 8'h80);
    rdc(1'b1, OFS_FC_TRG, 8'h00);
    wrr(1'b1, OFS_FEATURE_CONTROL, 8'h40);
    rdc(1'b0, OFS_SPR, 8'h03);
    wrr(1'b0, OFS_SPR, 8'h03);
    rdc(1'b0, OFS_SPR, 8'h03);
    rdc(1'b0, OFS_SPR, 8'h00);
    rdc(1'b0, OFS_SPR, 8'h03);
    wrr(1'b1, OFS_FEATURE_CONTROL, 8'h00);
    rdc(1'b0, OFS_SPR, 8'h5A);
    $display("count test done");
    cts = 1'b1;
    wrr(1'b1, OFS_EFR, 8'h80);
    wrr(1'b0, OFS_DATA, 8'hC3);
    repeat (4) @(negedge clk);
    chk({7'h00, txv}, 8'h00);
    cts = 1'b0;
    repeat (4) @(negedge clk);
    chk(got, 8'hC3);
    chk(gcnt, 8'h01);
    wrr(1'b1, OFS_FEATURE_CONTROL, 8'h80);
    wrr(1'b1, OFS_FC_TRG, 8'h08);
    wrr(1'b1, OFS_FEATURE_CONTROL, 8'h00);
    wrr(1'b1, OFS_FC_TRG, 8'h02);
    chk(trgtx, 8'h08);
    wrr(1'b0, OFS_MCR, 8'hE2);
    @(negedge clk);
    chk(modem_control, 8'h02);
    chk({7'h00, rts}, 8'h00);
    wrr(1'b1, OFS_EFR, 8'h40);
    @(negedge clk);
    chk({6'h00, rts, trig}, 8'h03);
    rdc(1'b0, OFS_DATA, 8'h41);
    rdc(1'b0, OFS_DATA, 8'h42);
    @(negedge clk);
    chk({6'h00, rts, trig}, 8'h00);
    $display("hardware flow test done");
    wrr(1'b1, OFS_PAU1, 8'h93);
    wrr(1'b1, OFS_PAU2, 8'h13);
    wrr(1'b1, OFS_RES2, 8'h11);
    wrr(1'b1, OFS_EFR, 8'h31);
    wrr(1'b0, OFS_IER, 8'h20);
    chk(interrupt_enable, 8'h20);
    wrr(1'b0, OFS_ISR_FCR, 8'h30);
    chk({6'h00, fcx}, 8'h03);
    rem_u.send(8'h13);
    repeat (2) @(negedge clk);
    chk({7'h00, flow}, 8'h01);
    rdc(1'b0, OFS_ISR_FCR, ISR_FLOW);
    rdc(1'b1, OFS_FC_TRG, 8'h01);
    wrr(1'b0, OFS_DATA, 8'h7E);
    repeat (4) @(negedge clk);
    chk(got, 8'hC3);
    rem_u.send(8'h11);
    repeat (4) @(negedge clk);
    chk(got, 8'h7E);
    wrr(1'b1, OFS_EFR, 8'h10);
    wrr(1'b1, OFS_EFR, 8'h32);
    rem_u.send(8'h13);
    rdc(1'b1, OFS_FC_TRG, 8'h02);
    rdc(1'b0, OFS_ISR_FCR, ISR_FLOW);
    slow = 1'b1;
    wrr(1'b1, OFS_EFR, 8'h10);
    wrr(1'b1, OFS_EFR, 8'h1C);
    repeat (8) @(negedge clk);
    chk(got, 8'h13);
    chk(gcnt, 8'h04);
    $display("software flow test done");
    end_sim;
  end
endmodule
